//--- logic/stl_cfg.svh
// offsets, field positions, reset values for the transmit level select block
`ifndef STL_CFG_SVH
`define STL_CFG_SVH

// per-quad register window: quad q starts at q * STL_QUAD_STRIDE
`define STL_QUAD_STRIDE      32'h0000_0010
`define STL_OFF_LANE_FIRST   4'h0
`define STL_OFF_LANE_SECOND  4'h4
`define STL_OFF_QUAD_CTL     4'h8
`define STL_OFF_LINK_CTL2    4'hc

// first lane register fields
`define STL_F_CDC_G1    3:0
`define STL_F_CDC_G2L   7:4
`define STL_F_CDC_G2H   11:8
`define STL_F_EQ_G1     15:12
`define STL_F_EQ_G2L    19:16
`define STL_F_EQ_G2H    23:20
`define STL_F_SLEW_G1   25:24
`define STL_F_FSLEW_G1  27:26
`define STL_F_SLEW_G2   29:28
`define STL_F_FSLEW_G2  31:30

// second lane register fields
`define STL_F_DRV_G1    4:0
`define STL_F_DRV_G2L   9:5
`define STL_F_DRV_G2H   14:10
`define STL_F_DRV_LSG1  18:15
`define STL_F_DRV_LSG2  22:19
`define STL_F_FDC_G1    25:23
`define STL_F_FDC_G2L   28:26
`define STL_F_FDC_G2H   31:29

// quad control and link control two fields
`define STL_F_LANE_SEL  1:0
`define STL_B_ALL_LANES 8
`define STL_F_MODE_RO   18:16
`define STL_F_MARGIN    2:0
`define STL_MARGIN_NORMAL 3'h0

// reset values of the lane, quad control and link control two registers
`define STL_RST_FIRST   32'h8a22_2333
`define STL_RST_SECOND  32'h9244_5294
`define STL_RST_QCTL    32'h0000_0100
`define STL_RST_LCTL2   32'h0000_0000

`endif

//--- logic/stl_pkg.sv
// types shared by the transmit level select block
package stl_pkg;

	typedef enum logic [2:0] {
		STL_FS_G1,
		STL_FS_G2_LOW,
		STL_FS_G2_HIGH,
		STL_LS_G1,
		STL_LS_G2
	} stl_mode_t;

endpackage

//--- logic/stl_tx_level_sel.sv
// per-quad, per-lane serdes transmit drive setting selection with apb registers
// Notes on behaviour
// - margin field at normal code: lane voltage comes from lane registers
// - other margin code: every lane of the port driven from margin field
// - each lane owns its own pair of lane control registers
// - merged port uses both quads' registers, or its margin on both quads
// - lane register writes go to one selected lane or all lanes
// - separate field sets for the three full-swing modes
// - low-swing modes use only drive level and slew fields
// - gen1 slew fields at 2.5 GT/s, gen2 slew at 5.0 GT/s
// - phy mode change switches lane settings to new mode's fields
// - lane registers reset to usable defaults and stay writable
// - parameter writes act immediately without any link retrain
// - nominal de-emphasis offset by coarse and fine steps per lane
// - first register slew, equalize, coarse de-emph; second fine, drive
// - merged port is even port plus next odd port over two quads
// - low swing is per link: all lanes of a port switch together
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_tx_level_sel
	import stl_pkg::*;
#(
	parameter int NUM_QUADS = 8,
	parameter int LANES     = 4,
	parameter int AW        = 12
) (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [AW-1:0]            paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// phy state per port
	input  wire logic [NUM_QUADS-1:0]     phy_gen2,
	input  wire logic [NUM_QUADS-1:0]     phy_deemph_high,
	input  wire logic [NUM_QUADS-1:0]     phy_low_swing,
	input  wire logic [NUM_QUADS/2-1:0]   port_merged,
	// per-lane analog settings
	output logic [NUM_QUADS*LANES*5-1:0]  tx_drive_level,
	output logic [NUM_QUADS*LANES*4-1:0]  tx_coarse_deemph,
	output logic [NUM_QUADS*LANES*3-1:0]  tx_fine_deemph,
	output logic [NUM_QUADS*LANES*4-1:0]  tx_equalize,
	output logic [NUM_QUADS*LANES*2-1:0]  tx_coarse_slew,
	output logic [NUM_QUADS*LANES*2-1:0]  tx_fine_slew,
	output logic [NUM_QUADS*LANES-1:0]    tx_margin_override,
	output logic [NUM_QUADS*LANES*3-1:0]  tx_margin_level
);

	localparam int NL = NUM_QUADS * LANES;
	localparam int LSW = $clog2(LANES);
	// quad control reset word as a constant, so the async reset branch stays static
	localparam logic [31:0] QCTL_RST = `STL_RST_QCTL;

	// lane and per-quad storage
	logic [31:0]           lane_tx_ctl_first_q  [NL];
	logic [31:0]           lane_tx_ctl_second_q [NL];
	logic [LSW-1:0]        quad_lane_sel_q      [NUM_QUADS];
	logic                  quad_all_lanes_q     [NUM_QUADS];
	logic [2:0]            transmit_margin_field_q [NUM_QUADS];

	// decoded bus access
	logic                  acc_setup;
	logic                  acc_write;
	logic                  addr_hit;
	logic [AW-1:0]         quad_idx_w;
	logic [3:0]            reg_off;
	int unsigned           quad_idx;

	// quad q is driven by its own port, or by the even port when merged
	function automatic int unsigned owner_port(input int unsigned q,
		input logic [NUM_QUADS/2-1:0] merged);
		owner_port = q;
		if (merged[q/2]) begin
			owner_port = q & ~32'd1;
		end
	endfunction

	// phy mode of a port; high de-emphasis only exists at gen2
	function automatic stl_mode_t mode_of(input logic gen2, input logic high,
		input logic low_swing);
		if (low_swing) begin
			mode_of = gen2 ? STL_LS_G2 : STL_LS_G1;
		end else if (!gen2) begin
			mode_of = STL_FS_G1;
		end else begin
			mode_of = high ? STL_FS_G2_HIGH : STL_FS_G2_LOW;
		end
	endfunction

	assign acc_setup  = psel && !penable;
	assign acc_write  = psel && penable && pwrite && pready;
	assign quad_idx_w = paddr >> 4;
	assign quad_idx   = 32'(quad_idx_w);
	assign reg_off    = paddr[3:0];
	assign addr_hit   = (quad_idx < NUM_QUADS) && (paddr[1:0] == 2'b00);

	// zero wait state slave
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// lane registers: write to the selected lane or to all lanes of the quad
	genvar gl;
	generate
		for (gl = 0; gl < NL; gl++) begin : g_lane_regs
			localparam int Q = gl / LANES;
			localparam int L = gl % LANES;
			logic lane_wr;
			assign lane_wr = acc_write && addr_hit && (quad_idx == Q) &&
				(quad_all_lanes_q[Q] || (quad_lane_sel_q[Q] == LSW'(L)));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lane_tx_ctl_first_q[gl] <= `STL_RST_FIRST;
				end else if (lane_wr && reg_off == `STL_OFF_LANE_FIRST) begin
					lane_tx_ctl_first_q[gl] <= pwdata;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lane_tx_ctl_second_q[gl] <= `STL_RST_SECOND;
				end else if (lane_wr && reg_off == `STL_OFF_LANE_SECOND) begin
					lane_tx_ctl_second_q[gl] <= pwdata;
				end
			end
		end
	endgenerate

	// per-quad control and per-port margin registers
	genvar gq;
	generate
		for (gq = 0; gq < NUM_QUADS; gq++) begin : g_quad_regs
			logic q_wr;
			assign q_wr = acc_write && addr_hit && (quad_idx == gq);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					quad_lane_sel_q[gq] <= LSW'(QCTL_RST[`STL_F_LANE_SEL]);
				end else if (q_wr && reg_off == `STL_OFF_QUAD_CTL) begin
					quad_lane_sel_q[gq] <= LSW'(pwdata[`STL_F_LANE_SEL]);
				end
			end

			// broadcast is the reset choice, so new defaults reach every lane at once
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					quad_all_lanes_q[gq] <= QCTL_RST[`STL_B_ALL_LANES];
				end else if (q_wr && reg_off == `STL_OFF_QUAD_CTL) begin
					quad_all_lanes_q[gq] <= pwdata[`STL_B_ALL_LANES];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					transmit_margin_field_q[gq] <= `STL_MARGIN_NORMAL;
				end else if (q_wr && reg_off == `STL_OFF_LINK_CTL2) begin
					transmit_margin_field_q[gq] <= pwdata[`STL_F_MARGIN];
				end
			end
		end
	endgenerate

	// read data, taken in the setup cycle and held through access
	logic [31:0] rd_d;
	stl_mode_t   rd_mode;
	int unsigned rd_lane;
	int unsigned rd_own;

	always_comb begin
		rd_d    = 32'h0000_0000;
		rd_mode = STL_FS_G1;
		rd_lane = 0;
		rd_own  = 0;
		if (addr_hit) begin
			rd_lane = quad_idx * LANES + 32'(quad_lane_sel_q[quad_idx]);
			// odd quad of a merged port reports the mode of the even port
			rd_own  = owner_port(quad_idx, port_merged);
			rd_mode = mode_of(phy_gen2[rd_own], phy_deemph_high[rd_own],
				phy_low_swing[rd_own]);
			case (reg_off)
				`STL_OFF_LANE_FIRST:  rd_d = lane_tx_ctl_first_q[rd_lane];
				`STL_OFF_LANE_SECOND: rd_d = lane_tx_ctl_second_q[rd_lane];
				`STL_OFF_QUAD_CTL: begin
					rd_d[`STL_F_LANE_SEL]  = 2'(quad_lane_sel_q[quad_idx]);
					rd_d[`STL_B_ALL_LANES] = quad_all_lanes_q[quad_idx];
					rd_d[`STL_F_MODE_RO]   = rd_mode;
				end
				`STL_OFF_LINK_CTL2: rd_d[`STL_F_MARGIN] = transmit_margin_field_q[quad_idx];
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (acc_setup && !pwrite) begin
			prdata <= rd_d;
		end
	end

	// per-lane selection of the field set for the current phy mode
	generate
		for (gl = 0; gl < NL; gl++) begin : g_lane_out
			localparam int Q = gl / LANES;
			logic [31:0] f;
			logic [31:0] s;
			int unsigned own;
			stl_mode_t   mode;
			logic [4:0]  drv_d;
			logic [3:0]  cdc_d;
			logic [2:0]  fdc_d;
			logic [3:0]  eq_d;
			logic [1:0]  slew_d;
			logic [1:0]  fslew_d;
			logic        ovr_d;
			logic [2:0]  lvl_d;

			assign f    = lane_tx_ctl_first_q[gl];
			assign s    = lane_tx_ctl_second_q[gl];
			assign own  = owner_port(Q, port_merged);
			assign mode = mode_of(phy_gen2[own], phy_deemph_high[own],
				phy_low_swing[own]);
			assign ovr_d = transmit_margin_field_q[own] != `STL_MARGIN_NORMAL;
			assign lvl_d = transmit_margin_field_q[own];

			// gen1 slew at 2.5 GT/s, gen2 slew at 5.0 GT/s
			assign slew_d  = phy_gen2[own] ? f[`STL_F_SLEW_G2] : f[`STL_F_SLEW_G1];
			assign fslew_d = phy_gen2[own] ? f[`STL_F_FSLEW_G2] : f[`STL_F_FSLEW_G1];

			always_comb begin
				drv_d = 5'h00;
				cdc_d = 4'h0;
				fdc_d = 3'h0;
				eq_d  = 4'h0;
				case (mode)
					STL_FS_G1: begin
						drv_d = s[`STL_F_DRV_G1];
						cdc_d = f[`STL_F_CDC_G1];
						fdc_d = s[`STL_F_FDC_G1];
						eq_d  = f[`STL_F_EQ_G1];
					end
					STL_FS_G2_LOW: begin
						drv_d = s[`STL_F_DRV_G2L];
						cdc_d = f[`STL_F_CDC_G2L];
						fdc_d = s[`STL_F_FDC_G2L];
						eq_d  = f[`STL_F_EQ_G2L];
					end
					STL_FS_G2_HIGH: begin
						drv_d = s[`STL_F_DRV_G2H];
						cdc_d = f[`STL_F_CDC_G2H];
						fdc_d = s[`STL_F_FDC_G2H];
						eq_d  = f[`STL_F_EQ_G2H];
					end
					// low swing: no de-emphasis, equalize and coarse unused
					STL_LS_G1: drv_d = {1'b0, s[`STL_F_DRV_LSG1]};
					STL_LS_G2: drv_d = {1'b0, s[`STL_F_DRV_LSG2]};
					default:   drv_d = 5'h00;
				endcase
			end

			// one flop stage so the analog side never sees decode glitches
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_drive_level[gl*5 +: 5] <= 5'h00;
				end else begin
					tx_drive_level[gl*5 +: 5] <= drv_d;
				end
			end

			// coarse and fine move together, so a de-emphasis step never lands half done
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_coarse_deemph[gl*4 +: 4] <= 4'h0;
					tx_fine_deemph[gl*3 +: 3]   <= 3'h0;
				end else begin
					tx_coarse_deemph[gl*4 +: 4] <= cdc_d;
					tx_fine_deemph[gl*3 +: 3]   <= fdc_d;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_equalize[gl*4 +: 4] <= 4'h0;
				end else begin
					tx_equalize[gl*4 +: 4] <= eq_d;
				end
			end

			// slew follows the rate only, so low swing keeps the slew of its rate
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_coarse_slew[gl*2 +: 2] <= 2'h0;
					tx_fine_slew[gl*2 +: 2]   <= 2'h0;
				end else begin
					tx_coarse_slew[gl*2 +: 2] <= slew_d;
					tx_fine_slew[gl*2 +: 2]   <= fslew_d;
				end
			end

			// margin travels beside the register drive level; the analog side picks one
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_margin_override[gl]     <= 1'b0;
					tx_margin_level[gl*3 +: 3] <= 3'h0;
				end else begin
					tx_margin_override[gl]     <= ovr_d;
					tx_margin_level[gl*3 +: 3] <= lvl_d;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

//--- dv/stl_tx_level_sel_props.sv
// concurrent checks on the transmit level select block ports
`timescale 1ns/1ps
`default_nettype none

module stl_tx_level_sel_props #(
	parameter int NUM_QUADS = 8,
	parameter int LANES     = 4,
	parameter int AW        = 12
) (
	// clock and reset
	input wire logic                         pclk,
	input wire logic                         presetn,
	// apb
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [AW-1:0]                paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	// phy state and lane settings
	input wire logic [NUM_QUADS-1:0]         phy_low_swing,
	input wire logic [NUM_QUADS/2-1:0]       port_merged,
	input wire logic [NUM_QUADS*LANES*5-1:0] tx_drive_level,
	input wire logic [NUM_QUADS*LANES*4-1:0] tx_coarse_deemph,
	input wire logic [NUM_QUADS*LANES*3-1:0] tx_fine_deemph,
	input wire logic [NUM_QUADS*LANES*4-1:0] tx_equalize,
	input wire logic [NUM_QUADS*LANES-1:0]   tx_margin_override,
	input wire logic [NUM_QUADS*LANES*3-1:0] tx_margin_level
);
	logic [2:0] margin0_q;
	logic       bad;

	assign bad = paddr[1:0] != 2'h0 || paddr[AW-1:4] >= NUM_QUADS;

	// shadow of port 0 margin code, seen only from the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			margin0_q <= 3'h0;
		end else if (psel && penable && pwrite && paddr == {{(AW-4){1'b0}}, 4'hc}) begin
			margin0_q <= pwdata[2:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_access: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_bad_addr: assert property (psel && penable && bad |-> pslverr)
		else $error("unmapped access not refused");
	a_good_addr: assert property (psel && penable && !bad |-> !pslverr)
		else $error("mapped access refused");
	a_bad_read: assert property (psel && penable && !pwrite && bad |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_margin_port: assert property (tx_margin_override[0] == ($past(margin0_q) != 3'h0)
		&& tx_margin_level[2:0] == $past(margin0_q))
		else $error("port 0 margin not applied one edge later");
	a_merged_margin: assert property (port_merged[0] && margin0_q != 3'h0
		|=> tx_margin_override[LANES])
		else $error("merged odd quad ignores margin");
	a_low_swing: assert property (phy_low_swing[0] |=> tx_equalize[LANES*4-1:0] == '0
		&& tx_coarse_deemph[LANES*4-1:0] == '0 && tx_fine_deemph[LANES*3-1:0] == '0)
		else $error("de-emphasis active in low swing");
	a_low_drive: assert property (phy_low_swing[0] |=> !tx_drive_level[4])
		else $error("low swing drive level too wide");
endmodule

bind stl_tx_level_sel stl_tx_level_sel_props #(.NUM_QUADS(NUM_QUADS), .LANES(LANES), .AW(AW)) i_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.phy_low_swing, .port_merged, .tx_drive_level, .tx_coarse_deemph, .tx_fine_deemph,
	.tx_equalize, .tx_margin_override, .tx_margin_level);

`default_nettype wire

//--- dv/tb_stl_tx_level_sel.sv
// self-checking bench for the transmit level select block
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module tb_stl_tx_level_sel;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, r, f, s, s2;
	logic [7:0]   phy_gen2, phy_deemph_high, phy_low_swing;
	logic [3:0]   port_merged;
	logic [159:0] tx_drive_level;
	logic [127:0] tx_coarse_deemph, tx_equalize;
	logic [95:0]  tx_fine_deemph, tx_margin_level;
	logic [63:0]  tx_coarse_slew, tx_fine_slew;
	logic [31:0]  tx_margin_override, rv [4];
	logic [2:0]   m, tm, mt [5];
	int           failures, num_checks, seed;

	stl_tx_level_sel i_stl_tx_level_sel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .phy_gen2, .phy_deemph_high, .phy_low_swing,
		.port_merged, .tx_drive_level, .tx_coarse_deemph, .tx_fine_deemph, .tx_equalize,
		.tx_coarse_slew, .tx_fine_slew, .tx_margin_override, .tx_margin_level);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	function automatic logic [31:0] lane(input int i);
		return {12'h0, tx_drive_level[i*5+:5], tx_coarse_deemph[i*4+:4], tx_fine_deemph[i*3+:3],
			tx_equalize[i*4+:4], tx_coarse_slew[i*2+:2], tx_fine_slew[i*2+:2]};
	endfunction

	// expected lane settings for a mode from the two lane registers
	function automatic logic [31:0] expl(input logic [2:0] md, input logic [31:0] a, input logic [31:0] b);
		logic [19:0] v;
		case (md)
			3'h0: v = {b[4:0], a[3:0], b[25:23], a[15:12], a[25:24], a[27:26]};
			3'h1: v = {b[9:5], a[7:4], b[28:26], a[19:16], a[29:28], a[31:30]};
			3'h2: v = {b[14:10], a[11:8], b[31:29], a[23:20], a[29:28], a[31:30]};
			3'h3: v = {1'b0, b[18:15], 11'h0, a[25:24], a[27:26]};
			default: v = {1'b0, b[22:19], 11'h0, a[29:28], a[31:30]};
		endcase
		return {12'h0, v};
	endfunction

	// phy bits {low swing, deemph high, gen2}; gen1 always takes -3.5 dB
	function automatic logic [2:0] md_of(input logic [2:0] b);
		return b[2] ? (b[0] ? 3'h4 : 3'h3) : (b[0] ? (b[1] ? 3'h2 : 3'h1) : 3'h0);
	endfunction

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			stop_test;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// lets the register or input change reach the lane outputs
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		{phy_gen2, phy_deemph_high, phy_low_swing} = 24'h0;
		port_merged = 4'h0;
		failures = 0;
		num_checks = 0;
		rv = '{`STL_RST_FIRST, `STL_RST_SECOND, `STL_RST_QCTL, `STL_RST_LCTL2};
		mt = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
		seed = $urandom(32'h26657133);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int q = 0; q < 8; q++) begin
			for (int o = 0; o < 4; o++) begin
				apb(1'b0, 12'(q * 16 + o * 4), 32'h0);
				chk("reset reg", rv[o], r);
			end
		end
		chk("reset lane", expl(3'h0, rv[0], rv[1]), lane(31));
		f = $urandom;
		s = $urandom;
		apb(1'b1, 12'h020, f);
		apb(1'b1, 12'h024, s);
		for (int k = 0; k < 12; k++) begin
			m = k < 5 ? mt[k] : 3'($urandom);
			@(posedge pclk);
			phy_low_swing <= {8{m[2]}};
			phy_deemph_high <= {8{m[1]}};
			phy_gen2 <= {8{m[0]}};
			settle;
			chk("mode lane", expl(md_of(m), f, s), lane(8));
			chk("mode peer", expl(md_of(m), f, s), lane(11));
			chk("other quad", expl(md_of(m), rv[0], rv[1]), lane(0));
			apb(1'b0, 12'h028, 32'h0);
			chk("mode field", {29'h0, md_of(m)}, {29'h0, r[18:16]});
		end
		s2 = $urandom;
		apb(1'b1, 12'h028, 32'h1);
		apb(1'b1, 12'h024, s2);
		settle;
		chk("chosen lane", expl(md_of(m), f, s2), lane(9));
		chk("other lane", expl(md_of(m), f, s), lane(10));
		apb(1'b0, 12'h024, 32'h0);
		chk("chosen read", s2, r);
		tm = 3'(1 + $urandom % 7);
		apb(1'b1, 12'h00c, {29'h0, tm}); // one step, bench link idle
		port_merged <= 4'h1;
		settle;
		for (int i = 0; i < 12; i++) begin
			chk("margin", {28'h0, 1'(i < 8), i < 8 ? tm : 3'h0},
				{28'h0, tx_margin_override[i], tx_margin_level[i*3+:3]});
		end
		apb(1'b1, 12'h00c, 32'h0);
		settle;
		chk("normal range", 32'h0, {31'h0, tx_margin_override[4]});
		apb(1'b0, 12'h080, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		apb(1'b1, 12'h022, 32'h0);
		chk("misaligned err", 32'h1, {31'h0, e});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h024, 32'h0);
		chk("second reset", rv[1], r);
		settle;
		chk("second reset lane", expl(md_of(m), rv[0], rv[1]), lane(9));
		stop_test;
	end
endmodule

`default_nettype wire
